// ### fill_cycle_timer.sv
// free-running fill-cycle timer producing one tick pulse per cycle
`default_nettype none
module fill_cycle_timer
    import leak_bucket_pkg::*;
#(
    parameter int unsigned CYCLE_CLKS = FILL_CYCLE_CLKS
) (
    input  wire logic mclk,
    input  wire logic rst,
    output var  logic tick
);
    localparam int CNT_W = $clog2(CYCLE_CLKS);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLE_CLKS - 1);

    logic [CNT_W-1:0] cnt_reg;
    logic             tick_reg;

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (cnt_reg == LAST);
            if (cnt_reg == LAST) begin
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    assign tick = tick_reg;
endmodule // fill_cycle_timer
`default_nettype wire

// ### leak_bucket.sv
// per-input leaky-bucket activity accumulators, decay control and output-2 strap register
`default_nettype none
module leak_bucket
    import leak_bucket_pkg::*;
#(
    parameter int NUM_INPUTS = 2,
    parameter int ACC_W      = 8,
    parameter int unsigned CYCLE_CLKS = FILL_CYCLE_CLKS
) (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire reg_req_type           reg_req,
    output var  logic [DATA_W-1:0]     rd_data,
    input  wire logic [NUM_INPUTS-1:0] input_bad,
    input  wire strap_type             strap_pins,
    output var  logic                  irq
);
    localparam logic [ACC_W-1:0] ACC_MAX = '1;
    localparam logic [ACC_W-1:0] ACC_ZERO = '0;
    localparam logic [RUN_W-1:0] RUN_ZERO = '0;

    function automatic logic [RUN_W-1:0] clean_run_len(input logic [LEAK_RATE_W-1:0] rate);
        clean_run_len = RUN_W'(1) << rate;
    endfunction

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // synchronisers and cycle timer
    // ------------------------------------------------------------
    logic [NUM_INPUTS-1:0] bad_meta_reg;
    logic [NUM_INPUTS-1:0] bad_sync_reg;
    strap_type             strap_meta_reg;
    strap_type             strap_sync_reg;
    logic                  tick;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bad_meta_reg   <= '0;
            bad_sync_reg   <= '0;
            strap_meta_reg <= '0;
            strap_sync_reg <= '0;
        end else begin
            bad_meta_reg   <= input_bad;
            bad_sync_reg   <= bad_meta_reg;
            strap_meta_reg <= strap_pins;
            strap_sync_reg <= strap_meta_reg;
        end
    end

    fill_cycle_timer #(
        .CYCLE_CLKS (CYCLE_CLKS)
    ) u_timer (
        .mclk (mclk),
        .rst  (rst),
        .tick (tick)
    );

    // ------------------------------------------------------------
    // registers written by software
    // ------------------------------------------------------------
    logic [LEAK_RATE_W-1:0] leak_rate_reg;
    logic [DATA_W-1:0]      out2_freq_reg;
    logic [DATA_W-1:0]      irq_mask_reg;
    logic [DATA_W-1:0]      irq_mask_next;
    logic [DATA_W-1:0]      irq_status_reg;
    logic [DATA_W-1:0]      irq_status_next;
    logic [DATA_W-1:0]      event_vec;
    strap_state_type        strap_state_reg;
    logic [1:0]             strap_cnt_reg;
    logic                   wr_hit_rate;
    logic                   wr_hit_freq;

    assign wr_hit_rate = reg_req.wr_en && (reg_req.addr == LEAK_RATE_OFS);
    assign wr_hit_freq = reg_req.wr_en && (reg_req.addr == OUT2_FREQ_OFS);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            leak_rate_reg <= LEAK_RATE_RESET[LEAK_RATE_W-1:0];
        end else if (wr_hit_rate) begin
            leak_rate_reg <= reg_req.wr_data[LEAK_RATE_W-1:0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_mask_reg <= '0;
        end else begin
            irq_mask_reg <= irq_mask_next;
        end
    end

    // the interrupt sees a new mask in the same cycle as the status it gates
    always_comb begin
        irq_mask_next = irq_mask_reg;
        if (reg_req.wr_en && (reg_req.addr == IRQ_MASK_OFS)) begin
            irq_mask_next = reg_req.wr_data;
        end
    end

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    // straps are read only once the synchroniser has filled after release
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            strap_state_reg <= STRAP_WAIT;
            strap_cnt_reg   <= '0;
            out2_freq_reg   <= OUT2_FREQ_RESET;
        end else begin
            case (strap_state_reg)
                STRAP_WAIT: begin
                    strap_cnt_reg <= strap_cnt_reg + 1'b1;
                    if (strap_cnt_reg == 2'(STRAP_SETTLE_CLKS - 1)) begin
                        strap_state_reg <= STRAP_LOAD;
                    end
                end
                STRAP_LOAD: begin
                    out2_freq_reg   <= {UPPER_NIBBLE_RESET, strap_sync_reg};
                    strap_state_reg <= STRAP_DONE;
                end
                STRAP_DONE: begin
                    if (wr_hit_freq) begin
                        out2_freq_reg <= reg_req.wr_data;
                    end
                end
                default: begin
                    strap_state_reg <= STRAP_WAIT;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // accumulators
    // ------------------------------------------------------------
    logic [ACC_W-1:0] acc_reg [NUM_INPUTS];
    logic [RUN_W-1:0] clean_reg [NUM_INPUTS];
    logic [NUM_INPUTS-1:0] seen_reg;
    logic [NUM_INPUTS-1:0] cycle_bad;
    logic [NUM_INPUTS-1:0] fill_evt;
    logic [NUM_INPUTS-1:0] leak_evt;

    for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_bucket
        // a fault anywhere inside the cycle marks it bad, even on its last clock
        assign cycle_bad[i] = seen_reg[i] | bad_sync_reg[i];
        assign fill_evt[i]  = tick && cycle_bad[i] && (acc_reg[i] != ACC_MAX);
        assign leak_evt[i]  = tick && !cycle_bad[i]
                              && (clean_reg[i] + 1'b1 == clean_run_len(leak_rate_reg))
                              && (acc_reg[i] != ACC_ZERO);

        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                seen_reg[i] <= 1'b0;
            end else if (tick) begin
                seen_reg[i] <= 1'b0;
            end else if (bad_sync_reg[i]) begin
                seen_reg[i] <= 1'b1;
            end
        end

        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                clean_reg[i] <= RUN_ZERO;
            end else if (tick) begin
                if (cycle_bad[i] || (clean_reg[i] + 1'b1 >= clean_run_len(leak_rate_reg))) begin
                    clean_reg[i] <= RUN_ZERO;
                end else begin
                    clean_reg[i] <= clean_reg[i] + 1'b1;
                end
            end
        end

        // saturates at both ends; the bucket size limit is ACC_MAX, all ones across ACC_W
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                acc_reg[i] <= ACC_ZERO;
            end else if (fill_evt[i]) begin
                acc_reg[i] <= acc_reg[i] + 1'b1;
            end else if (leak_evt[i]) begin
                acc_reg[i] <= acc_reg[i] - 1'b1;
            end
        end

        a_fill_step: assert property (tick && cycle_bad[i] && acc_reg[i] != ACC_MAX
            |=> acc_reg[i] == $past(acc_reg[i]) + 1'b1) else $error("bad cycle did not fill");
        a_acc_quiet: assert property (!tick |=> $stable(acc_reg[i]))
            else $error("accumulator moved between cycles");
        a_leak_step: assert property (tick && !cycle_bad[i] && acc_reg[i] != ACC_ZERO
            && clean_reg[i] + 1'b1 == clean_run_len(leak_rate_reg)
            |=> acc_reg[i] == $past(acc_reg[i]) - 1'b1) else $error("clean run did not leak");
        a_run_restart: assert property (tick && cycle_bad[i] |=> clean_reg[i] == RUN_ZERO)
            else $error("bad cycle kept clean run");
        a_slow_hold: assert property (tick && !cycle_bad[i] && leak_rate_reg == 2'b11
            && clean_reg[i] == RUN_ZERO |=> clean_reg[i] == 4'h1 && $stable(acc_reg[i]))
            else $error("slowest rate leaked early");
        a_fast_leak: assert property (tick && !cycle_bad[i] && leak_rate_reg == 2'b00
            && acc_reg[i] != ACC_ZERO |=> acc_reg[i] == $past(acc_reg[i]) - 1'b1)
            else $error("fill-rate decay missed");

        // a run still open counts up and leaves the bucket alone
        sequence s_run_open;
            tick && !cycle_bad[i] && (clean_reg[i] + 1'b1 < clean_run_len(leak_rate_reg));
        endsequence
        sequence s_run_step;
            clean_reg[i] == $past(clean_reg[i]) + 1'b1;
        endsequence
        a_run_count: assert property (s_run_open |=> s_run_step)
            else $error("clean run did not advance");
        a_run_no_leak: assert property (s_run_open |=> $stable(acc_reg[i]))
            else $error("bucket leaked before the run closed");
    end : g_bucket

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    always_comb begin
        event_vec = '0;
        event_vec[NUM_INPUTS-1:0] = fill_evt;
        event_vec[2*NUM_INPUTS-1:NUM_INPUTS] = leak_evt;
    end

    // a new event in the clearing cycle stays set
    always_comb begin
        irq_status_next = irq_status_reg;
        if (reg_req.wr_en && (reg_req.addr == IRQ_STATUS_OFS)) begin
            irq_status_next = irq_status_reg & ~reg_req.wr_data;
        end
        irq_status_next = irq_status_next | event_vec;
    end

    logic irq_reg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_status_reg <= '0;
            irq_reg        <= 1'b0;
        end else begin
            irq_status_reg <= irq_status_next;
            irq_reg        <= |(irq_status_next & irq_mask_next);
        end
    end

    assign irq = irq_reg;

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_data_next;

    always_comb begin
        rd_data_next = '0;
        case (reg_req.addr)
            LEAK_RATE_OFS:  rd_data_next = DATA_W'(leak_rate_reg);
            OUT2_FREQ_OFS:  rd_data_next = out2_freq_reg;
            IRQ_STATUS_OFS: rd_data_next = irq_status_reg;
            IRQ_MASK_OFS:   rd_data_next = irq_mask_reg;
            default: begin
                for (int k = 0; k < NUM_INPUTS; k++) begin
                    if (reg_req.addr == ACC_BASE_OFS + ADDR_W'(k)) begin
                        rd_data_next = DATA_W'(acc_reg[k]);
                    end
                end
            end
        endcase
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_data_reg <= '0;
        end else if (reg_req.rd_en) begin
            rd_data_reg <= rd_data_next;
        end else begin
            rd_data_reg <= '0;
        end
    end

    assign rd_data = rd_data_reg;

    a_rate_unused: assert property (reg_req.rd_en && reg_req.addr == LEAK_RATE_OFS
        |=> rd_data[DATA_W-1:LEAK_RATE_W] == '0) else $error("unused decay bits read nonzero");
    a_strap_load: assert property (strap_state_reg == STRAP_LOAD
        |=> out2_freq_reg == {UPPER_NIBBLE_RESET, $past(strap_sync_reg)})
        else $error("strap value not loaded");
    a_irq_level: assert property (irq == |(irq_status_reg & irq_mask_reg))
        else $error("interrupt does not follow masked status");
    a_status_hold: assert property (!(reg_req.wr_en && reg_req.addr == IRQ_STATUS_OFS)
        |=> (irq_status_reg & $past(irq_status_reg)) == $past(irq_status_reg))
        else $error("status bit dropped without a clear");
    a_rd_idle: assert property (!reg_req.rd_en |=> rd_data == '0)
        else $error("read data stood outside its cycle");
endmodule // leak_bucket
`default_nettype wire

// ### leak_bucket_pkg.sv
// constants, register map and carrier types of the leaky-bucket activity block
`default_nettype none
package leak_bucket_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned FILL_CYCLE_MS = 128;
    localparam int unsigned NS_PER_MS     = 1_000_000;
    localparam int unsigned FILL_CYCLE_CLKS = FILL_CYCLE_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int unsigned STRAP_SETTLE_CLKS = 3;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] LEAK_RATE_OFS  = 4'h0;
    localparam logic [ADDR_W-1:0] OUT2_FREQ_OFS  = 4'h1;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 4'h2;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS   = 4'h3;
    localparam logic [ADDR_W-1:0] ACC_BASE_OFS   = 4'h4;

    localparam logic [DATA_W-1:0] LEAK_RATE_RESET = 8'h01;
    localparam logic [DATA_W-1:0] OUT2_FREQ_RESET = 8'h00;
    localparam int LEAK_RATE_W = 2;
    localparam int NIBBLE_W    = 4;
    localparam logic [NIBBLE_W-1:0] UPPER_NIBBLE_RESET = 4'h0;
    localparam int FREQ_STRAP_W = 3;
    localparam int RUN_W        = 4;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wr_data;
        logic              wr_en;
        logic              rd_en;
    } reg_req_type;

    typedef struct packed {
        logic                    sonet_not_sdh_strap;
        logic [FREQ_STRAP_W-1:0] out2_freq_strap;
    } strap_type;

    typedef enum logic [1:0] {
        STRAP_WAIT = 2'b00,
        STRAP_LOAD = 2'b01,
        STRAP_DONE = 2'b10
    } strap_state_type;
endpackage
`default_nettype wire

// ### leak_bucket_tb.sv
// self-checking bench for the leaky-bucket activity block
`default_nettype none
`define CHK(got, exp) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
end

module leak_bucket_tb
    import leak_bucket_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    // short fill cycle so that the slowest leak rate fits a short run
    localparam int unsigned CYC = 16;

    logic              mclk;
    logic              rst;
    reg_req_type       reg_req;
    logic [DATA_W-1:0] rd_data;
    logic [1:0]        input_bad;
    strap_type         strap_pins;
    logic              irq;
    int                n_mismatch;
    int                check_count;
    time               t0;
    time               t1;

    leak_bucket #(
        .NUM_INPUTS (2),
        .ACC_W      (8),
        .CYCLE_CLKS (CYC)
    ) uut (
        .mclk       (mclk),
        .rst        (rst),
        .reg_req    (reg_req),
        .rd_data    (rd_data),
        .input_bad  (input_bad),
        .strap_pins (strap_pins),
        .irq        (irq)
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // bus and event tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        reg_req <= '{addr: a, wr_data: d, wr_en: 1'b1, rd_en: 1'b0};
        @(posedge mclk);
        reg_req <= '0;
    endtask

    // data is looked at only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge mclk);
        reg_req <= '{addr: a, wr_data: 8'h00, wr_en: 1'b0, rd_en: 1'b1};
        @(posedge mclk);
        reg_req <= '0;
        @(negedge mclk);
        `CHK(rd_data, exp)
    endtask

    // clears status, then stamps the next rise of irq; rises mirror events exactly
    task automatic wait_ev(output time t);
        bit seen_low;
        int i;
        seen_low = 1'b0;
        t = 0;
        wr(IRQ_STATUS_OFS, 8'hFF);
        for (i = 0; i < 2000; i++) begin
            @(negedge mclk);
            if (irq === 1'b1 && seen_low) break;
            if (irq === 1'b0) seen_low = 1'b1;
        end
        if (i == 2000) begin
            n_mismatch++;
            finish_test();
        end else begin
            t = $time;
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst         = 1'b1;
        reg_req     = '0;
        input_bad   = 2'b00;
        strap_pins  = '{sonet_not_sdh_strap: 1'b1, out2_freq_strap: 3'b101};
        n_mismatch  = 0;
        check_count = 0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        // straps must stay put until the capture has finished
        repeat (8) @(posedge mclk);
        rd(LEAK_RATE_OFS, LEAK_RATE_RESET);
        rd(OUT2_FREQ_OFS, 8'h0D);
        wr(LEAK_RATE_OFS, 8'hFF);
        rd(LEAK_RATE_OFS, 8'h03);
        wr(OUT2_FREQ_OFS, 8'hA5);
        rd(OUT2_FREQ_OFS, 8'hA5);
        rd(4'hF, 8'h00);
        wr(ACC_BASE_OFS, 8'h55);
        rd(ACC_BASE_OFS, 8'h00);
        // empty bucket must not leak below zero, even at the fastest rate
        wr(LEAK_RATE_OFS, 8'h00);
        repeat (CYC + 2) @(posedge mclk);
        rd(IRQ_STATUS_OFS, 8'h00);

        // fill: input 0 bad every cycle, one event per fill cycle
        wr(IRQ_MASK_OFS, 8'h01);
        @(posedge mclk);
        input_bad <= 2'b01;
        wait_ev(t0);
        for (int k = 1; k < 12; k++) begin
            wait_ev(t1);
            `CHK(t1 - t0, 64'(CYC * CLK_PERIOD_NS))
            t0 = t1;
        end
        // the window already open still sees the bad level
        @(posedge mclk);
        input_bad <= 2'b00;
        wait_ev(t1);
        rd(ACC_BASE_OFS, 8'h0D);
        rd(ACC_BASE_OFS + 4'h1, 8'h00);

        // leak: every rate, one sync then one measured gap
        wr(IRQ_MASK_OFS, 8'h04);
        for (int r = 3; r >= 0; r--) begin
            wr(LEAK_RATE_OFS, 8'(r));
            wait_ev(t0);
            wait_ev(t1);
            `CHK(t1 - t0, 64'(CYC * CLK_PERIOD_NS * (1 << r)))
        end
        rd(ACC_BASE_OFS, 8'h05);

        // masked event stays quiet, status is sticky and clears by one
        wr(LEAK_RATE_OFS, 8'h03);
        wr(IRQ_MASK_OFS, 8'h00);
        repeat (4) @(negedge mclk);
        `CHK(irq, 1'b0)
        rd(IRQ_STATUS_OFS, 8'h04);
        wr(IRQ_STATUS_OFS, 8'h04);
        rd(IRQ_STATUS_OFS, 8'h00);

        // second reset with other straps: capture repeats, upper nibble clears
        @(posedge mclk);
        rst        <= 1'b1;
        strap_pins <= '{sonet_not_sdh_strap: 1'b0, out2_freq_strap: 3'b011};
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (8) @(posedge mclk);
        rd(OUT2_FREQ_OFS, 8'h03);
        rd(LEAK_RATE_OFS, LEAK_RATE_RESET);
        rd(ACC_BASE_OFS, 8'h00);
        finish_test();
    end
endmodule // leak_bucket_tb

`undef CHK
`default_nettype wire
